/* ignition_pkg.sv */
// Purpose: shared constants for the ignition supervisor
// Assumes: 250 MHz system clock
// Notes:   timing figures kept in their own units, counts derived
package ignition_pkg;
  localparam int CLOCK_MHZ        = 250;
  localparam int MAX_CYL          = 8;
  localparam int RETARD_MAX_DEG   = 35;
  localparam int ANALOG_BITS      = 10;
  localparam int RETARD_BITS      = 6;
  localparam int SPEED_BITS       = 16;
  localparam logic [15:0] OVERSPEED_RPM_DEF = 16'h0898;  // 2200 rpm
  localparam logic [15:0] SECURITY_RPM_DEF  = 16'h015E;  // 350 rpm
  localparam logic [7:0]  PIN_COUNT_DEF     = 8'h17;     // 23 pins
  localparam logic        CONTACT_STOP_DEF  = 1'b0;      // 0 = shutdown mode
  // zero-speed declared after this long with no trigger or reset pin
  localparam int ZERO_SPEED_MS    = 500;
  localparam int ZERO_SPEED_CYC   = ZERO_SPEED_MS * CLOCK_MHZ * 1000;
  typedef enum logic [3:0] {
    ST_STOPPED = 4'h1,
    ST_VERIFY  = 4'h2,
    ST_RUN     = 4'h4,
    ST_FAULT   = 4'h8
  } state_type;
endpackage

/* sync2.sv */
// Purpose: two-flop synchroniser for pin inputs
// Assumes: input asynchronous to clock
// Notes:   first stage read only by second stage
`timescale 1ns/100ps
module sync2 #(
  parameter int WIDTH = 1
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             rst,
  // data
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] stage1;

  // plain double register
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      stage1 <= '0;
      dout   <= '0;
    end else begin
      stage1 <= din;
      dout   <= stage1;
    end
  end
endmodule // sync2

/* ignition_supervisor.sv */
// Purpose: supervisory control of firing, fuel permit and contact input
// Assumes: pickups already squared up; speed measured elsewhere
// Notes:   one clock; analog value already digitised
// Behaviour
// - fuel permit drops whenever ignition stops
// - permit only after signals verified and firing
// - contact mode selectable, shutdown by default
// - grounded contact in shutdown mode suppresses firing
// - ground above security speed needs zero speed
// - open below security speed fires at once
// - selector mode switches schedule A/B while running
// - trigger checked against pin count each revolution
// - mismatch stops after one further revolution
// - analog input scaled into retard, capped
// - up to eight outputs fired in order
// - overspeed limit shuts ignition down
`timescale 1ns/100ps
module ignition_supervisor #(
  parameter int             CYLINDERS    = ignition_pkg::MAX_CYL,
  parameter int             ZERO_CYC     = ignition_pkg::ZERO_SPEED_CYC,
  parameter logic [15:0]    OVERSPEED    = ignition_pkg::OVERSPEED_RPM_DEF,
  parameter logic [15:0]    SECURITY     = ignition_pkg::SECURITY_RPM_DEF,
  parameter logic [7:0]     PIN_COUNT    = ignition_pkg::PIN_COUNT_DEF
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst,
  // configuration
  input  wire logic        contactSelectsSchedule,
  // pins (asynchronous)
  input  wire logic        triggerPin,
  input  wire logic        resetPin,
  input  wire logic        camPin,
  input  wire logic        contactGrounded,
  input  wire logic [9:0]  analogLevel,
  // measured speed (same clock)
  input  wire logic [15:0] speedRpm,
  // outputs
  output logic [7:0]       fireOut,
  output logic             fuel_permit_signal,
  output logic             scheduleB,
  output logic [5:0]       retardDeg,
  output logic             patternFault,
  output logic             zeroSpeedPending
);
  localparam int ZW = $clog2(ZERO_CYC + 1);

  logic trig;
  logic rstp;
  logic cam;
  logic contact;
  logic [9:0] analogSync;
  logic trigLast;
  logic rstLast;
  logic trigRise;
  logic revRise;

  ignition_pkg::state_type state;
  ignition_pkg::state_type next_state;
  logic [7:0]  pinCount;
  logic [7:0]  next_pinCount;
  logic [2:0]  cylIdx;
  logic [2:0]  next_cylIdx;
  logic        faultArmed;
  logic        next_faultArmed;
  logic        zeroPend;
  logic        next_zeroPend;
  logic [ZW-1:0] idleCount;
  logic [ZW-1:0] next_idleCount;
  logic        sawCam;
  logic        next_sawCam;
  logic [7:0]  next_fireOut;
  logic        next_scheduleB;
  logic [5:0]  next_retardDeg;
  logic [15:0] retardProd;
  logic        shutContact;
  logic        atZero;
  logic [9:0]  analogPrev;
  logic [9:0]  analogStable;
  logic [9:0]  next_analogStable;

  // pins pass two flops before use
  sync2 #(.WIDTH(14)) u_sync (
    .clock (clock),
    .rst   (rst),
    .din   ({triggerPin, resetPin, camPin, contactGrounded, analogLevel}),
    .dout  ({trig, rstp, cam, contact, analogSync})
  );

  assign trigRise    = trig & ~trigLast;
  assign revRise     = rstp & ~rstLast;
  // shutdown mode is the default when the select is low
  assign shutContact = ~contactSelectsSchedule & contact;
  assign atZero      = (idleCount == ZW'(ZERO_CYC));
  // linear scale of full range onto 0..34 degrees, truncated
  assign retardProd  = 16'(analogStable * 6'(ignition_pkg::RETARD_MAX_DEG));

  // next-state logic of the supervisor
  always_comb begin
    next_state      = state;
    next_pinCount   = pinCount;
    next_cylIdx     = cylIdx;
    next_faultArmed = faultArmed;
    next_zeroPend   = zeroPend;
    next_sawCam     = sawCam | cam;
    next_fireOut    = '0;
    next_scheduleB  = scheduleB;
    next_retardDeg  = retardProd[15:10];
    // word taken only once two samples agree, so a skewed change never reaches retard
    next_analogStable = (analogSync == analogPrev) ? analogSync : analogStable;
    next_idleCount  = idleCount;
    // a revolution mark is motion too, so a restart is not taken for a stop
    if (trigRise || revRise) begin
      next_idleCount = '0;
    end else if (!atZero) begin
      next_idleCount = idleCount + ZW'(1);
    end
    // selector mode follows contact even while running
    if (contactSelectsSchedule) begin
      next_scheduleB = contact;
    end
    // ground above security speed latches the zero-speed wait
    if (shutContact && speedRpm > SECURITY) begin
      next_zeroPend = 1'b1;
    end else if (atZero) begin
      next_zeroPend = 1'b0;
    end
    if (trigRise) begin
      next_pinCount = pinCount + 8'h01;
    end
    case (state)
      ignition_pkg::ST_STOPPED: begin
        next_faultArmed = 1'b0;
        // open contact below security speed fires at once once verified
        if (!shutContact && !zeroPend && speedRpm < SECURITY && revRise) begin
          next_state    = ignition_pkg::ST_VERIFY;
          next_pinCount = '0;
          next_sawCam   = 1'b0;
        end
      end
      ignition_pkg::ST_VERIFY: begin
        // a full revolution with right pin count and cam seen
        if (revRise) begin
          next_pinCount = '0;
          next_sawCam   = 1'b0;
          if (pinCount == PIN_COUNT && sawCam) begin
            next_state  = ignition_pkg::ST_RUN;
            next_cylIdx = '0;
          end
        end
      end
      ignition_pkg::ST_RUN: begin
        // fire cylinders in firing order, one per slot
        if (trigRise && pinCount < 8'(CYLINDERS)) begin
          next_fireOut[cylIdx] = 1'b1;
          next_cylIdx = (cylIdx == 3'(CYLINDERS - 1)) ? 3'h0 : cylIdx + 3'h1;
        end
        if (revRise) begin
          next_pinCount = '0;
          next_cylIdx   = '0;
          // check pattern each revolution
          if (pinCount != PIN_COUNT) begin
            next_faultArmed = 1'b1;
          end
          // one more full revolution after the mismatch, then stop
          if (faultArmed) begin
            next_state = ignition_pkg::ST_FAULT;
          end
        end
      end
      ignition_pkg::ST_FAULT: begin
        if (atZero) begin
          next_state = ignition_pkg::ST_STOPPED;
        end
      end
      default: next_state = ignition_pkg::ST_STOPPED;
    endcase
    // overspeed, contact or zero-speed wait stop firing
    if (state == ignition_pkg::ST_RUN || state == ignition_pkg::ST_VERIFY) begin
      if (speedRpm >= OVERSPEED) begin
        next_state = ignition_pkg::ST_FAULT;
      end else if (shutContact || next_zeroPend || atZero) begin
        next_state = ignition_pkg::ST_STOPPED;
      end
    end
    if (next_state != ignition_pkg::ST_RUN) begin
      next_fireOut = '0;
    end
  end

  // register the supervisor state
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state      <= ignition_pkg::ST_STOPPED;
      pinCount   <= '0;
      cylIdx     <= '0;
      faultArmed <= 1'b0;
      zeroPend   <= 1'b0;
      idleCount  <= '0;
      sawCam     <= 1'b0;
      fireOut    <= '0;
      scheduleB  <= 1'b0;
      retardDeg  <= '0;
      trigLast   <= 1'b0;
      rstLast    <= 1'b0;
      analogPrev   <= '0;
      analogStable <= '0;
    end else begin
      state      <= next_state;
      pinCount   <= next_pinCount;
      cylIdx     <= next_cylIdx;
      faultArmed <= next_faultArmed;
      zeroPend   <= next_zeroPend;
      idleCount  <= next_idleCount;
      sawCam     <= next_sawCam;
      fireOut    <= next_fireOut;
      scheduleB  <= next_scheduleB;
      retardDeg  <= next_retardDeg;
      trigLast   <= trig;
      rstLast    <= rstp;
      analogPrev   <= analogSync;
      analogStable <= next_analogStable;
    end
  end

  // permit only while running and nothing suppresses
  assign fuel_permit_signal = (state == ignition_pkg::ST_RUN) & ~shutContact
                              & ~zeroPend;
  assign patternFault       = (state == ignition_pkg::ST_FAULT);
  assign zeroSpeedPending   = zeroPend;

  // checks
  a_permit_run: assert property (@(posedge clock) disable iff (rst)
    fuel_permit_signal |-> state == ignition_pkg::ST_RUN)
    else $error("permit outside run");
  a_permit_verify: assert property (@(posedge clock) disable iff (rst)
    state == ignition_pkg::ST_VERIFY |-> !fuel_permit_signal)
    else $error("permit during verify");
  // permit may only come up straight out of verification
  a_permit_rise: assert property (@(posedge clock) disable iff (rst)
    $rose(fuel_permit_signal) |-> $past(state) == ignition_pkg::ST_VERIFY)
    else $error("permit without verification");
  // the cycle after a grounded contact is seen nothing may fire
  a_contact_nofire: assert property (@(posedge clock) disable iff (rst)
    shutContact |=> fireOut == 8'h00)
    else $error("fired with contact grounded");
  a_zero_wait: assert property (@(posedge clock) disable iff (rst)
    zeroPend |=> fireOut == 8'h00)
    else $error("fired during zero-speed wait");
  a_overspeed_stop: assert property (@(posedge clock) disable iff (rst)
    state == ignition_pkg::ST_RUN && speedRpm >= OVERSPEED
    |=> state == ignition_pkg::ST_FAULT)
    else $error("overspeed not stopped");
  a_schedule_sel: assert property (@(posedge clock) disable iff (rst)
    contactSelectsSchedule |=> scheduleB == $past(contact))
    else $error("schedule not followed");
  a_retard_cap: assert property (@(posedge clock) disable iff (rst)
    retardDeg <= 6'h23)
    else $error("retard above limit");
  a_one_hot_fire: assert property (@(posedge clock) disable iff (rst)
    $onehot0(fireOut))
    else $error("more than one output fired");
  // an overspeed trip may land mid-revolution, so it is left out here
  a_fault_delay: assert property (@(posedge clock) disable iff (rst)
    $rose(state == ignition_pkg::ST_FAULT) && $past(faultArmed)
    && $past(speedRpm) < OVERSPEED |-> $past(revRise))
    else $error("fault stop not on revolution");
  // suppression drops the permit now and keeps it down after the stop
  a_permit_contact: assert property (@(posedge clock) disable iff (rst)
    shutContact || zeroPend |-> !fuel_permit_signal ##1 !fuel_permit_signal)
    else $error("permit with contact grounded");
  c_run: cover property (@(posedge clock) disable iff (rst) state == ignition_pkg::ST_RUN);
  c_fault: cover property (@(posedge clock) disable iff (rst) state == ignition_pkg::ST_FAULT);
  c_zero: cover property (@(posedge clock) disable iff (rst) $fell(zeroPend));
  c_sched: cover property (@(posedge clock) disable iff (rst) $rose(scheduleB));
endmodule // ignition_supervisor

/* engine_model.sv */
// Purpose: engine pickups seen by the supervisor
// Assumes: pulses three clocks wide so the synchroniser sees them
// Notes:   pickups idle low between pulses and while stopped
`timescale 1ns/100ps
module engine_model (
  // clock
  input  wire logic       clock,
  // bench control
  input  wire logic       spin,
  input  wire logic [7:0] pinsPerRev,
  // pickups
  output logic            triggerPin,
  output logic            resetPin,
  output logic            camPin
);
  task automatic hold(input int n);
    repeat (n) @(negedge clock);
  endtask
  // one revolution: reset mark, then trigger pins, cam beside the first
  initial begin
    triggerPin = 1'b0;
    resetPin   = 1'b0;
    camPin     = 1'b0;
    forever begin
      @(negedge clock);
      if (spin) begin
        resetPin = 1'b1;
        hold(3);
        resetPin = 1'b0;
        // count read at each pin, so a change takes effect in this revolution
        for (int i = 0; i < pinsPerRev; i++) begin
          hold(4);
          triggerPin = 1'b1;
          camPin     = (i == 0);
          hold(3);
          triggerPin = 1'b0;
          camPin     = 1'b0;
        end
        hold(4);
      end
    end
  end
endmodule // engine_model

/* tb.sv */
// Purpose: self-checking bench for the ignition supervisor
// Assumes: zero-speed count shortened; engine model drives pickups
// Notes:   inputs change at the falling edge; fixed seed
`timescale 1ns/100ps
module tb;
  localparam int ZC = 50;
  logic        clock, rst, sel, grounded, spin, quiet;
  logic        trig, rev, cam, permit, schedB, fault, zeroWait, prev;
  logic [7:0]  pins, fireOut;
  logic [9:0]  analog;
  logic [15:0] speed;
  logic [5:0]  retard;
  logic [31:0] seed = 32'h0000AA45;
  int          failCount, totalChecks, cycles, nextCyl, fires;
  ignition_supervisor #(.ZERO_CYC(ZC)) uut (.clock(clock), .rst(rst),
    .contactSelectsSchedule(sel), .triggerPin(trig), .resetPin(rev), .camPin(cam),
    .contactGrounded(grounded), .analogLevel(analog), .speedRpm(speed),
    .fireOut(fireOut), .fuel_permit_signal(permit), .scheduleB(schedB),
    .retardDeg(retard), .patternFault(fault), .zeroSpeedPending(zeroWait));
  engine_model eng (.clock(clock), .spin(spin), .pinsPerRev(pins),
    .triggerPin(trig), .resetPin(rev), .camPin(cam));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // linear scale, truncated, so full scale stays under the cap
  function automatic logic [5:0] retardOf(input logic [9:0] a);
    return 6'((a * 35) / 1024);
  endfunction
  task automatic check(input logic ok, input string msg);
    totalChecks++;
    if (ok !== 1'b1) begin
      failCount++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  // bounded wait, about seven revolutions at most
  task automatic waitPermit(input logic v);
    for (int k = 0; k < 1200 && permit !== v; k++) cyc(1);
    check(permit === v, "permit level wrong");
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", totalChecks, failCount);
    if (failCount == 0 && totalChecks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  // each revolution restarts the cylinder order
  always @(posedge rev) nextCyl = 0;
  // fire pulses must be one-hot, in turn, and absent while suppressed
  always @(posedge clock) begin
    cycles++;
    if (!rst && fireOut !== 8'h00) begin
      fires++;
      check(!quiet && fireOut === (8'h01 << nextCyl), "fire out of turn");
      nextCyl = (nextCyl + 1) % 8;
    end
    if (cycles == 8000) begin
      failCount++;
      conclude();
    end
  end
  initial begin
    {rst, quiet} = 2'b11;
    {sel, grounded, spin} = {ignition_pkg::CONTACT_STOP_DEF, 2'b00};
    pins = 8'h17;
    analog = 10'h000;
    speed = 16'h0000;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    check(permit === 1'b0 && fireOut === 8'h00 && fault === 1'b0, "reset outputs");
    speed = 16'(rnd() % 300);
    spin = 1'b1;
    @(posedge rev);
    cyc(20);
    check(permit === 1'b0, "permit before verify");
    waitPermit(1'b1);
    {quiet, fires} = 0;
    @(posedge rev);
    check(fires == 8, "fire count per revolution");
    $display("test start done");
    grounded = 1'b1;
    cyc(4);
    quiet = 1'b1;
    cyc(200);
    check(permit === 1'b0, "permit while grounded");
    @(posedge rev);
    {grounded, quiet} = 2'b00;
    waitPermit(1'b1);
    $display("test contact done");
    sel = 1'b1;
    for (int i = 0; i < 4; i++) begin
      prev = schedB;
      grounded = ~grounded;
      cyc(6);
      check(schedB !== prev && permit === 1'b1, "schedule swap");
    end
    sel = 1'b0;
    $display("test schedule done");
    for (int i = 0; i < 12; i++) begin
      analog = (i == 0) ? 10'h000 : (i == 1) ? 10'h3FF : 10'(rnd());
      cyc(6);
      check(retard === retardOf(analog), "retard value");
    end
    $display("test retard done");
    @(posedge rev);
    pins = 8'h16;
    @(posedge rev);
    cyc(6);
    check(permit === 1'b1 && fault === 1'b0, "stopped too early");
    @(posedge rev);
    quiet = 1'b1;
    cyc(6);
    check(fault === 1'b1 && permit === 1'b0, "no stop after bad revolution");
    {spin, pins} = {1'b0, 8'h17};
    // the model ends its revolution before the pickups go quiet
    cyc(ZC + 250);
    check(fault === 1'b0, "fault kept at zero speed");
    $display("test pattern done");
    {quiet, spin} = 2'b01;
    waitPermit(1'b1);
    speed = 16'h01F4;
    grounded = 1'b1;
    cyc(4);
    quiet = 1'b1;
    cyc(6);
    check(zeroWait === 1'b1, "no zero wait above security");
    @(posedge rev);
    grounded = 1'b0;
    cyc(400);
    check(permit === 1'b0 && zeroWait === 1'b1, "restart before zero");
    {spin, speed} = 17'h00000;
    cyc(ZC + 250);
    check(zeroWait === 1'b0, "zero wait not cleared");
    {quiet, spin} = 2'b01;
    speed = 16'(rnd() % 300);
    waitPermit(1'b1);
    $display("test security done");
    speed = 16'h0898;
    cyc(2);
    quiet = 1'b1;
    cyc(4);
    check(permit === 1'b0 && fault === 1'b1, "overspeed ignored");
    spin = 1'b0;
    $display("test overspeed done");
    conclude();
  end
endmodule // tb
